// ### rhwc_pkg.sv
// constants and carrier types for the reset, halt and watchdog controller
package rhwc_pkg;

  // ==========================================================
  // register file locations (bank, address)
  localparam logic [3:0] BANK_F           = 4'hF;
  localparam logic [7:0] ADDR_WDT_MODE    = 8'h0F;
  localparam logic [7:0] ADDR_STOP_REC    = 8'h0B;
  localparam logic [7:0] ADDR_OUT_CFG     = 8'h00;

  // ==========================================================
  // field positions
  localparam int SRC_DELAY_BIT   = 5;  // stop recovery delay select
  localparam int SRC_STATUS_BIT  = 7;  // read-only recovery status
  localparam int WDT_CLKFREE_BIT = 4;  // zero enables clock-free reset
  localparam int OCFG_OSC_BIT    = 7;  // zero selects low-emi oscillator
  localparam int OCFG_PORT_LSB   = 0;  // one bit per port group
  localparam int NUM_PORT_EMI    = 3;

  // ==========================================================
  // reset values
  localparam logic [7:0] WDT_MODE_RST = 8'h00;
  localparam logic [7:0] STOP_REC_RST = 8'h00;
  localparam logic [7:0] OUT_CFG_RST  = 8'hFF;
  localparam logic [7:0] READ_ZERO    = 8'h00;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS     = 4000;
  localparam int STOP_REC_WIDTH_PS = 12000;
  localparam int STOP_REC_MIN_CYC  =
    (STOP_REC_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RESET_DELAY_TIME_US = 5000;
  localparam int WDT_WINDOW_CYC      = 60;
  localparam int LOW_EMI_MAX_HZ      = 4000000;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rhwc_reg_req_type;

  typedef struct packed {
    logic power_good;    // supply ok level
    logic stop_recovery; // stop recovery source level
    logic wdt_timeout;   // watchdog expiry pulse
    logic in_stop;       // core sits in stop mode
    logic halt_exec;     // core executed halt
    logic irq_taken;     // enabled interrupt accepted
    logic first_instr;   // first instruction fetched
    logic rc_tick;       // dedicated rc oscillator tick
  } rhwc_evt_type;

  typedef enum logic [0:0] {
    ST_DELAY,
    ST_RUN
  } rhwc_fsm_type;

endpackage : rhwc_pkg

// ### rhwc_ctrl.sv
// reset delay, halt gating and watchdog mode register control
//
// Functional notes
// - delay starts on power, recovery, watchdog
// - delay counted on rc ticks, core held
// - delay nominally five milliseconds long
// - halt gates cpu clock, peripherals keep running
// - taken interrupt, delay trigger or recovery without delay leaves halt
// - watchdog stop timeout keeps registers, starts delay
// - watchdog mode writable sixty cycles only
// - watchdog mode at bank F 0Fh, unreadable
// - clear D4 makes timeout default io pins
// - low-emi oscillator and ports selectable, 4 MHz
// - stop recovery config write-only except D7
// - recovery pulse at least 12 ns wide
`timescale 1ns/1ps
module rhwc_ctrl #(
  parameter int RC_FREQ_KHZ = 1000
) (
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire rhwc_pkg::rhwc_evt_type    evt,
  input  wire rhwc_pkg::rhwc_reg_req_type req,
  output logic [7:0]                     rdata,
  output logic                           core_rst_n,
  output logic                           cpu_clk_en,
  output logic                           periph_clk_en,
  output logic                           io_default,
  output logic                           low_emi_osc,
  output logic                           sys_clk_limit,
  output logic [2:0]                     port_low_emi,
  output logic [7:0]                     wdt_mode
);
  import rhwc_pkg::*;

  // ==========================================================
  // derived counts
  localparam int DELAY_TICKS = RESET_DELAY_TIME_US * RC_FREQ_KHZ / 1000;
  localparam int DW          = $clog2(DELAY_TICKS + 1);
  localparam logic [DW-1:0] DELAY_LAST = DW'(DELAY_TICKS - 1);
  localparam logic [6:0] WIN_LAST = 7'(WDT_WINDOW_CYC - 1);
  localparam logic [1:0] REC_LAST = 2'(STOP_REC_MIN_CYC - 1);

  // ==========================================================
  // state
  typedef struct packed {
    rhwc_fsm_type  fsm;
    logic [DW-1:0] dcnt;
    logic [1:0]    rcnt;
    logic          rec_seen;
    logic          pg_prev;
    logic          win_armed;
    logic          win_open;
    logic [6:0]    wcnt;
    logic          halt;
    logic [7:0]    wmode;
    logic [7:0]    src;
    logic [7:0]    ocfg;
    logic          rst_n;
    logic          clk_en;
    logic          io_def;
    logic [7:0]    rdata;
  } rhwc_state_type;

  rhwc_state_type s_q;
  rhwc_state_type s_d;

  logic trig;
  logic rec_ok;
  logic hit_wmode;
  logic hit_src;
  logic hit_ocfg;

  // ==========================================================
  // decode and trigger terms
  assign hit_wmode = (req.bank == BANK_F) && (req.addr == ADDR_WDT_MODE);
  assign hit_src   = (req.bank == BANK_F) && (req.addr == ADDR_STOP_REC);
  assign hit_ocfg  = (req.bank == BANK_F) && (req.addr == ADDR_OUT_CFG);
  // recovery qualified by pulse width
  assign rec_ok = evt.stop_recovery && evt.in_stop
                  && (s_q.rcnt == REC_LAST) && !s_q.rec_seen;
  // three sources of the one-shot delay
  assign trig = (evt.power_good && !s_q.pg_prev)
              || (rec_ok && !s_q.src[SRC_DELAY_BIT])
              || evt.wdt_timeout;

  // ==========================================================
  // next state
  always_comb begin
    s_d = s_q;
    s_d.pg_prev = evt.power_good;
    // width filter on the recovery source
    if (!evt.stop_recovery) begin
      s_d.rcnt     = '0;
      s_d.rec_seen = 1'b0;
    end else if (s_q.rcnt != REC_LAST) begin
      s_d.rcnt = s_q.rcnt + 2'd1;
    end else begin
      s_d.rec_seen = s_q.rec_seen | rec_ok;
    end
    // one-shot delay on rc ticks
    case (s_q.fsm)
      ST_DELAY: begin
        if (evt.rc_tick) begin
          if (s_q.dcnt == DELAY_LAST) begin
            s_d.fsm       = ST_RUN;
            s_d.rst_n     = 1'b1;
            s_d.io_def    = 1'b0;
            s_d.win_armed = 1'b1;
          end else begin
            s_d.dcnt = s_q.dcnt + DW'(1);
          end
        end
      end
      ST_RUN: ;
      default: s_d.fsm = ST_DELAY;
    endcase
    // watchdog mode write window after first instruction
    if (s_q.win_open) begin
      if (s_q.wcnt == WIN_LAST) begin
        s_d.win_open = 1'b0;
      end else begin
        s_d.wcnt = s_q.wcnt + 7'd1;
      end
    end else if (s_q.win_armed && evt.first_instr && s_q.rst_n) begin
      s_d.win_armed = 1'b0;
      s_d.win_open  = 1'b1;
      s_d.wcnt      = '0;
    end
    // recovery without delay re-arms the window and clears halt
    if (rec_ok && s_q.src[SRC_DELAY_BIT]) begin
      s_d.win_armed = 1'b1;
      s_d.halt      = 1'b0;
    end
    if (rec_ok) begin
      s_d.src[SRC_STATUS_BIT] = 1'b1;
    end
    // halt entry and interrupt exit
    if (s_q.halt && evt.irq_taken) begin
      s_d.halt = 1'b0;
    end else if (evt.halt_exec && s_q.fsm == ST_RUN) begin
      s_d.halt = 1'b1;
    end
    // register writes
    if (req.wr && hit_wmode && s_q.win_open) begin
      s_d.wmode = req.wdata;
    end
    if (req.wr && hit_src) begin
      s_d.src = {s_d.src[SRC_STATUS_BIT], // keeps a same-cycle set
                 req.wdata[SRC_STATUS_BIT-1:0]};
    end
    if (req.wr && hit_ocfg) begin
      s_d.ocfg = req.wdata;
    end
    // reads: mode unreadable, recovery config shows D7 only
    s_d.rdata = READ_ZERO;
    if (req.rd && hit_src) begin
      s_d.rdata[SRC_STATUS_BIT] = s_q.src[SRC_STATUS_BIT];
    end else if (req.rd && hit_ocfg) begin
      s_d.rdata = s_q.ocfg;
    end
    // any trigger restarts the delay; registers untouched except D7, which power-good clears
    if (trig) begin
      s_d.fsm       = ST_DELAY;
      s_d.dcnt      = '0;
      s_d.rst_n     = 1'b0;
      s_d.halt      = 1'b0;
      s_d.win_armed = 1'b0;
      s_d.win_open  = 1'b0;
      if (evt.wdt_timeout && !s_q.wmode[WDT_CLKFREE_BIT]) begin
        s_d.io_def = 1'b1;
      end
      if (evt.power_good && !s_q.pg_prev) begin
        s_d.src[SRC_STATUS_BIT] = 1'b0;
      end
    end
    s_d.clk_en = s_d.rst_n && !s_d.halt;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q           <= '0;
      s_q.fsm       <= ST_DELAY;
      s_q.wmode     <= WDT_MODE_RST;
      s_q.src       <= STOP_REC_RST;
      s_q.ocfg      <= OUT_CFG_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // outputs straight from state
  assign rdata         = s_q.rdata;
  assign core_rst_n    = s_q.rst_n;
  assign cpu_clk_en    = s_q.clk_en;
  assign periph_clk_en = s_q.rst_n;  // timers and irqs run in halt
  assign io_default    = s_q.io_def;
  assign low_emi_osc   = !s_q.ocfg[OCFG_OSC_BIT];
  assign sys_clk_limit = !s_q.ocfg[OCFG_OSC_BIT]; // cap at LOW_EMI_MAX_HZ
  assign port_low_emi  = s_q.ocfg[OCFG_PORT_LSB +: NUM_PORT_EMI];
  assign wdt_mode      = s_q.wmode;

  // ==========================================================
  // checks
  property p_trig_resets;
    @(posedge clk) disable iff (!arst_n)
    evt.wdt_timeout |=> !core_rst_n && s_q.fsm == ST_DELAY;
  endproperty
  a_trig_resets: assert property (p_trig_resets)
    else $error("timeout did not start reset delay");

  property p_delay_release;
    @(posedge clk) disable iff (!arst_n)
    (s_q.fsm == ST_DELAY && evt.rc_tick && s_q.dcnt == DELAY_LAST
     && !trig) |=> core_rst_n && s_q.fsm == ST_RUN;
  endproperty
  a_delay_release: assert property (p_delay_release)
    else $error("reset not released at terminal count");

  property p_held_in_delay;
    @(posedge clk) disable iff (!arst_n)
    s_q.fsm == ST_DELAY |-> !core_rst_n && !cpu_clk_en;
  endproperty
  a_held_in_delay: assert property (p_held_in_delay)
    else $error("core reset released during delay");

  property p_rc_only;
    @(posedge clk) disable iff (!arst_n)
    (s_q.fsm == ST_DELAY && !evt.rc_tick && !trig)
      |=> $stable(s_q.dcnt) && !core_rst_n;
  endproperty
  a_rc_only: assert property (p_rc_only)
    else $error("delay advanced without rc tick");

  property p_halt_gate;
    @(posedge clk) disable iff (!arst_n)
    s_q.halt |-> !cpu_clk_en && periph_clk_en;
  endproperty
  a_halt_gate: assert property (p_halt_gate)
    else $error("cpu clock running in halt");

  property p_halt_exit;
    @(posedge clk) disable iff (!arst_n)
    (s_q.halt && !evt.irq_taken && !trig && !rec_ok) |=> s_q.halt;
  endproperty
  a_halt_exit: assert property (p_halt_exit)
    else $error("halt left without interrupt");

  property p_keep_cfg;
    @(posedge clk) disable iff (!arst_n)
    (evt.wdt_timeout && evt.in_stop && !req.wr)
      |=> $stable(s_q.ocfg) && $stable(s_q.wmode);
  endproperty
  a_keep_cfg: assert property (p_keep_cfg)
    else $error("timeout in stop altered config");

  property p_wmode_locked;
    @(posedge clk) disable iff (!arst_n)
    (req.wr && hit_wmode && !s_q.win_open) |=> $stable(wdt_mode);
  endproperty
  a_wmode_locked: assert property (p_wmode_locked)
    else $error("watchdog mode changed outside window");

  property p_wmode_unread;
    @(posedge clk) disable iff (!arst_n)
    (req.rd && hit_wmode) |=> rdata == READ_ZERO;
  endproperty
  a_wmode_unread: assert property (p_wmode_unread)
    else $error("watchdog mode register was readable");

  property p_io_default;
    @(posedge clk) disable iff (!arst_n)
    (evt.wdt_timeout && !wdt_mode[WDT_CLKFREE_BIT]) |=> io_default;
  endproperty
  a_io_default: assert property (p_io_default)
    else $error("io pins not defaulted on timeout");

  property p_src_read;
    @(posedge clk) disable iff (!arst_n)
    (req.rd && hit_src) |=> rdata[SRC_STATUS_BIT-1:0] == '0;
  endproperty
  a_src_read: assert property (p_src_read)
    else $error("write-only recovery bits were readable");

  property p_short_rec;
    @(posedge clk) disable iff (!arst_n)
    rec_ok |-> evt.stop_recovery && $past(evt.stop_recovery)
               && $past(evt.stop_recovery, 2);
  endproperty
  a_short_rec: assert property (p_short_rec)
    else $error("short recovery pulse accepted");

  property p_emi;
    @(posedge clk) disable iff (!arst_n)
    (req.wr && hit_ocfg) |=> low_emi_osc == !$past(req.wdata[OCFG_OSC_BIT]);
  endproperty
  a_emi: assert property (p_emi)
    else $error("oscillator emi select not applied");

endmodule : rhwc_ctrl

// ### rhwc_core_model.sv
// behavioural processor core facing the controller
`timescale 1ns/1ps
module rhwc_core_model (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       core_rst_n,
  input  wire logic       cpu_clk_en,
  input  wire logic       halt_cmd,
  input  wire logic       irq_cmd,
  input  wire logic [3:0] lag,
  output logic            first_instr,
  output logic            halt_exec,
  output logic            irq_taken
);
  logic       run_q;
  logic       nop_q;
  logic [4:0] cnt_q;
  // ==========================================================
  // fetch after reset, nop ahead of halt, irq accept while halted
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q       <= 1'b0;
      nop_q       <= 1'b0;
      cnt_q       <= 5'h00;
      first_instr <= 1'b0;
      halt_exec   <= 1'b0;
      irq_taken   <= 1'b0;
    end else begin
      run_q       <= core_rst_n;
      cnt_q       <= !core_rst_n ? 5'h00 :
                     !run_q ? {1'b0, lag} + 5'h01 :
                     (cnt_q != 5'h00) ? cnt_q - 5'h01 : 5'h00;
      first_instr <= (cnt_q == 5'h01); // slow or prompt fetch
      nop_q       <= halt_cmd && cpu_clk_en;
      halt_exec   <= nop_q;
      irq_taken   <= irq_cmd && !cpu_clk_en;
    end
  end
endmodule : rhwc_core_model

// ### testbench.sv
// self-checking bench for the reset, halt and watchdog controller
`timescale 1ns/1ps
module testbench;
  import rhwc_pkg::*;
  logic             clk, arst_n, pg, sr, wto, ist, rct, hcmd, icmd;
  logic             fi, hx, it, core_rst_n, cpu_clk_en, periph_clk_en;
  logic             io_default, low_emi_osc, sys_clk_limit;
  logic [3:0]       lag;
  logic [2:0]       port_low_emi;
  logic [7:0]       rdata, wdt_mode, got;
  rhwc_evt_type     evt;
  rhwc_reg_req_type req;
  int               miscompares, n_compared, seed, oc, wm;
  // ==========================================================
  // clock, event bundle, design and core model
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  assign evt = '{pg, sr, wto, ist, hx, it, fi, rct};
  rhwc_ctrl #(.RC_FREQ_KHZ(2)) u_rhwc_ctrl (
    .clk(clk), .arst_n(arst_n), .evt(evt), .req(req), .rdata(rdata),
    .core_rst_n(core_rst_n), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .io_default(io_default),
    .low_emi_osc(low_emi_osc), .sys_clk_limit(sys_clk_limit),
    .port_low_emi(port_low_emi), .wdt_mode(wdt_mode));
  rhwc_core_model u_rhwc_core_model (
    .clk(clk), .arst_n(arst_n), .core_rst_n(core_rst_n),
    .cpu_clk_en(cpu_clk_en), .halt_cmd(hcmd), .irq_cmd(icmd), .lag(lag),
    .first_instr(fi), .halt_exec(hx), .irq_taken(it));
  // ==========================================================
  // shared tasks
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [7:0] d);
    @(posedge clk);
    req <= '{w, !w, BANK_F, a, d};
    @(posedge clk);
    req <= '0;
    #1;
    got = rdata;
  endtask : acc
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      rct <= 1'b1;
      @(posedge clk);
      rct <= 1'b0;
    end
    cyc(2);
  endtask : ticks
  task automatic delay_run(input logic io);
    chk("core_rst_n", 8'h00, {7'h0, core_rst_n});
    chk("io_default", {7'h0, io}, {7'h0, io_default});
    ticks(9);
    chk("held", 8'h00, {7'h0, core_rst_n | cpu_clk_en});
    ticks(1);
    chk("released", 8'h01, {7'h0, core_rst_n & cpu_clk_en});
    chk("io_end", 8'h00, {7'h0, io_default});
    lag = 4'($random(seed) & 7);
    cyc(12);
  endtask : delay_run
  task automatic regs();
    chk("wdt_mode", wm[7:0], wdt_mode);
    chk("out_cfg", {3'h0, ~oc[7], ~oc[7], oc[2:0]},
        {3'h0, low_emi_osc, sys_clk_limit, port_low_emi});
  endtask : regs
  task automatic recov(input int n);
    @(posedge clk);
    sr <= 1'b1;
    repeat (n) @(posedge clk);
    sr <= 1'b0;
    cyc(2);
  endtask : recov
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  // ==========================================================
  // watchdog against a hang
  initial begin
    #40000;
    miscompares++;
    stop_test();
  end
  // ==========================================================
  // main sequence
  initial begin
    seed = 45594;
    {pg, sr, wto, ist, rct, hcmd, icmd} = 7'h40;
    {arst_n, req, lag, miscompares, n_compared, oc, wm} = '0;
    oc = 8'hFF;
    cyc(4);
    regs();
    @(posedge clk);
    arst_n <= 1'b1;
    cyc(1);
    delay_run(1'b0);
    wm = $random(seed) & 8'hEF;
    acc(1'b1, ADDR_WDT_MODE, wm[7:0]);
    acc(1'b0, ADDR_WDT_MODE, 8'h00);
    chk("wdt_read", READ_ZERO, got);
    cyc(70);
    acc(1'b1, ADDR_WDT_MODE, ~wm[7:0]);
    for (int i = 0; i < 4; i++) begin
      oc = ($random(seed) & 8'h7F) | ((i & 1) << 7);
      acc(1'b1, ADDR_OUT_CFG, oc[7:0]);
      regs();
    end
    acc(1'b0, 8'h33, 8'h00);
    chk("unmapped", 8'h00, got);
    acc(1'b1, ADDR_STOP_REC, 8'h9F);
    acc(1'b0, ADDR_STOP_REC, 8'h00);
    chk("stop_rec", 8'h00, got);
    // halt entry with peripherals running, interrupt exit
    @(posedge clk);
    hcmd <= 1'b1;
    @(posedge clk);
    hcmd <= 1'b0;
    cyc(3);
    chk("halt", 8'h01, {7'h0, ~cpu_clk_en & periph_clk_en});
    cyc(20);
    chk("halt_hold", 8'h00, {7'h0, cpu_clk_en});
    @(posedge clk);
    icmd <= 1'b1;
    @(posedge clk);
    icmd <= 1'b0;
    cyc(3);
    chk("halt_exit", 8'h01, {7'h0, cpu_clk_en});
    // watchdog expiry in stop, clock-free io reset
    @(posedge clk);
    ist <= 1'b1;
    wto <= 1'b1;
    @(posedge clk);
    wto <= 1'b0;
    cyc(2);
    delay_run(1'b1);
    regs();
    wm = wm ^ 8'h01;
    acc(1'b1, ADDR_WDT_MODE, wm[7:0]);
    regs();
    // recovery pulses: too short, recognised, then bypassed
    recov(2);
    chk("short_pulse", 8'h01, {7'h0, core_rst_n});
    recov(5);
    delay_run(1'b0);
    acc(1'b0, ADDR_STOP_REC, 8'h00);
    chk("stop_flag", 8'h80, got);
    acc(1'b1, ADDR_STOP_REC, 8'h20);
    recov(5);
    chk("bypass", 8'h01, {7'h0, core_rst_n});
    // power fail then power good
    @(posedge clk);
    pg <= 1'b0;
    ist <= 1'b0;
    @(posedge clk);
    pg <= 1'b1;
    cyc(2);
    delay_run(1'b0);
    acc(1'b0, ADDR_STOP_REC, 8'h00);
    chk("flag_clear", 8'h00, got);
    stop_test();
  end
endmodule : testbench
